//--- rtl/vicd_defs.svh
`ifndef VICD_DEFS_SVH
`define VICD_DEFS_SVH
// register byte offsets
`define VICD_OFS_CTRL     8'h00
`define VICD_OFS_PRIO     8'h04
`define VICD_OFS_DELAY    8'h08
`define VICD_OFS_LTC      8'h0C
`define VICD_OFS_TIMES    8'h10
`define VICD_OFS_ERRMASK  8'h14
`define VICD_OFS_STATUS   8'h18
`define VICD_OFS_ERRCNT   8'h1C
`define VICD_OFS_PHASE    8'h20
`define VICD_OFS_CMD      8'h24
// command bits
`define VICD_CMD_CNT_CLR  0
`define VICD_CMD_LATCH    1
// reset values
`define VICD_RST_PRIO     12'h0000
`define VICD_RST_HOLD     16'h0010
`define VICD_RST_LOCK     16'h0010
`define VICD_RST_MASK     16'hFFFF
// limits
`define VICD_LTC_MAX      32000
`define VICD_FRAMES_MAX   3'h7
`define VICD_SC_PHASES    8
// audio samples per frame for the time code sum, 25 frames a second
`define VICD_FRAME_SMP    1920
`endif

//--- rtl/vicd_pkg.sv
package vicd_pkg;
   // source choices for a priority level
   typedef enum logic [2:0] {
      SRC_NONE, SRC_ELEC, SRC_OPT, SRC_GEN, SRC_MUTE
   } vicd_src_type;
   // video in mode
   typedef enum logic [1:0] {
      MODE_AUTO, MODE_MAN_ELEC, MODE_MAN_OPT
   } vicd_mode_type;
   // time code channel pairing
   typedef enum logic {
      left_right_channel_pairing, duplicated_single_channel
   } vicd_pair_type;
   // per-input qualification state
   typedef struct packed {
      logic        valid;
      logic [15:0] cnt;
   } vicd_qual_type;
   // status bundle
   typedef struct packed {
      logic elec_present;
      logic opt_present;
      logic locked;
   } vicd_stat_type;
endpackage : vicd_pkg

//--- rtl/vicd_top.sv
`include "vicd_defs.svh"
// input change-over and delay control for the processed video path
// one clock, one synchronous active-low reset, one wishbone slave
// the video itself never passes through here, only its control
// selection runs in manual or automatic priority mode
// automatic mode walks three levels, top level first
// fallbacks: internal black generator, mute, or frame freeze
// input presence is qualified by hold and lock counters
// delays are stored here and handed on to the delay line
// time code delay is the video delay plus a signed extra part
// error counter only counts flags let through by the mask
// status reads show qualified presence, level and source
// all state sits in one packed struct, next value built in one process

module vicd_top #(
   parameter int ERR_W = 16
) (
   input  wire logic        mclk_i,
   input  wire logic        rst_n_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic        wb_we_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   output logic             wb_ack_o,
   input  wire logic        elec_sig_i,
   input  wire logic        opt_sig_i,
   input  wire logic        opt_fitted_i,
   input  wire logic        reclk_lock_i,
   input  wire logic        frame_tick_i,
   input  wire logic [15:0] phase_meas_i,
   input  wire logic [15:0] err_flags_i,
   input  wire logic [15:0] ltc_ch1_i,
   input  wire logic [15:0] ltc_ch2_i,
   output logic [2:0]       sel_src_o,
   output logic             freeze_o,
   output logic             gen_black_o,
   output logic             drv_off_o,
   output logic [2:0]       frame_delay_o,
   output logic [15:0]      phase_delay_o,
   output logic [2:0]       sc_phase_o,
   output logic [15:0]      ltc_delay_o,
   output logic [15:0]      ltc_left_o,
   output logic [15:0]      ltc_right_o
);
   // state layout notes
   // bus-written settings and derived outputs share one struct
   // so a single reset assignment covers every flop at once
   // sync stages carry fitted, electrical, optical and lock pins
   // bit order of sync stages: 3 fitted, 2 elec, 1 opt, 0 lock
   // qualifier pairs hold a valid flag and a run counter each
   // level is the active priority row, src what it resolves to
   // read data is registered so the bus sees a settled word
   // whole-block state, one struct
   typedef struct packed {
      logic [3:0]  sync_a;          // first sync stage, read only by sync_b
      logic [3:0]  sync_b;          // second sync stage
      logic [1:0]  mode;
      logic [2:0]  prio0;
      logic [2:0]  prio1;
      logic [2:0]  prio2;
      logic [2:0]  frames;
      logic [15:0] phase;           // signed phase delay in samples
      logic [15:0] ltc_rel;         // signed extra time code delay
      logic        pair;
      logic [15:0] hold_t;
      logic [15:0] lock_t;
      logic [15:0] mask;
      logic [ERR_W-1:0] errcnt;
      vicd_pkg::vicd_qual_type qe;
      vicd_pkg::vicd_qual_type qo;
      logic [1:0]  lvl;             // active priority level
      logic [2:0]  scph;
      logic [2:0]  src;
      logic [15:0] ltc_dly;
      logic [15:0] ltc_l;
      logic [15:0] ltc_r;
      logic [31:0] rdat;
      logic        ack;
   } st_type;
   st_type s_reg, s_next;

   // level lookup notes
   // generator and mute never drop out, so any row below them
   // can never be reached by the fallback walk
   // such rows read back as none and select nothing
   // the raw written code is still kept, only its use is blanked
   // used by selection and by the priority read path alike
   // source at a level, blanked when unreachable behind generator or mute
   function automatic logic [2:0] eff_prio(input logic [1:0] l, input st_type s);
      logic [2:0] v;
      v = (l == 2'd0) ? s.prio0 : (l == 2'd1) ? s.prio1 : s.prio2;
      if (l >= 2'd1 && (s.prio0 == 3'(vicd_pkg::SRC_GEN) || s.prio0 == 3'(vicd_pkg::SRC_MUTE)))
         v = 3'(vicd_pkg::SRC_NONE);
      if (l == 2'd2 && (s.prio1 == 3'(vicd_pkg::SRC_GEN) || s.prio1 == 3'(vicd_pkg::SRC_MUTE)))
         v = 3'(vicd_pkg::SRC_NONE);
      return v;
   endfunction : eff_prio

   // liveness notes
   // physical inputs count as live only once qualified
   // a raw pin glitch therefore never moves the selection
   // generator and mute are internal and always live
   // none is never live, so the walk steps past it
   // codes above mute are unused and treated as none
   // is the source at hand live (generator and mute always are)
   function automatic logic src_ok(input logic [2:0] src, input st_type s);
      case (src)
         3'(vicd_pkg::SRC_ELEC): return s.qe.valid;
         3'(vicd_pkg::SRC_OPT):  return s.qo.valid;
         3'(vicd_pkg::SRC_GEN):  return 1'b1;
         3'(vicd_pkg::SRC_MUTE): return 1'b1;
         default:                return 1'b0;
      endcase
   endfunction : src_ok

   // qualifier notes
   // counter runs only while pin and valid flag disagree
   // any agreement restarts the count from zero
   // a present pin must stay for lock time before valid
   // an absent pin must stay gone for hold time before invalid
   // trade-off: long hold rides out dropouts but delays fallback
   // qualification of one input by hold and lock times
   function automatic vicd_pkg::vicd_qual_type qualify(input vicd_pkg::vicd_qual_type q,
         input logic sig, input logic [15:0] hold_t, input logic [15:0] lock_t);
      vicd_pkg::vicd_qual_type r;
      r = q;
      if (sig == q.valid) begin
         r.cnt = 16'h0000;
      end else if (q.cnt >= (q.valid ? hold_t : lock_t)) begin
         r.valid = sig;
         r.cnt   = 16'h0000;
      end else begin
         r.cnt = q.cnt + 16'h0001;
      end
      return r;
   endfunction : qualify

   // combinational helpers, all rebuilt every cycle
   // req is low while ack stands, so one request
   // is taken once and never twice
   // cmd_wr flags a write to the command word
   logic        req;                // bus request this cycle
   logic [2:0]  cur;                // source at active level
   logic [1:0]  nl;
   logic        found;
   logic [31:0] ltc_sum;
   logic [31:0] vid_smp;
   logic        cmd_wr;

   assign req    = wb_cyc_i & wb_stb_i & ~s_reg.ack;
   assign cmd_wr = req & wb_we_i & (wb_adr_i == `VICD_OFS_CMD) & wb_sel_i[0];

   // next-state logic
   always_comb begin
      s_next = s_reg;
      nl = 2'd0;
      found = 1'b0;
      // pin levels arrive from other clocks
      // nothing but the second stage reads the first one
      // the fitted gate is applied after sync, never before,
      // since logic ahead of the first flop defeats the synchroniser
      // an unfitted optical input simply never qualifies
      // two-stage synchronisers for pins
      s_next.sync_a = {opt_fitted_i, elec_sig_i, opt_sig_i, reclk_lock_i};
      s_next.sync_b = s_reg.sync_a;
      s_next.qe = qualify(s_reg.qe, s_reg.sync_b[2], s_reg.hold_t, s_reg.lock_t);
      s_next.qo = qualify(s_reg.qo, s_reg.sync_b[1] & s_reg.sync_b[3], s_reg.hold_t,
                          s_reg.lock_t);
      // error counter notes
      // flags come from the same clock, no sync needed
      // any masked-in flag in a cycle adds one
      // counter saturates rather than wrapping to zero
      // an error in the clear cycle is kept, so none is lost
      // error counting, clear wins only without a new error
      if (cmd_wr && wb_dat_i[`VICD_CMD_CNT_CLR])
         s_next.errcnt = '0;
      if ((err_flags_i & s_reg.mask) != 16'h0000 && s_next.errcnt != '1)
         s_next.errcnt = s_next.errcnt + ERR_W'(1);
      // subcarrier notes
      // three bits wrap naturally after eight frames
      // no reset of the phase other than the block reset
      // subcarrier phase advances once a frame
      if (frame_tick_i)
         s_next.scph = s_reg.scph + 3'd1;
      // selection notes
      // manual modes pin the source and never fall back;
      // a lost manual input freezes the last frame instead
      // auto mode is latching: the level only changes on loss or on a latch reset
      // on loss, the first live level from the top is taken,
      // which is also the background search while all are gone
      // if nothing is live the level stays, and freeze follows
      // latch reset forces the top level even if it is absent;
      // the walk then runs again on the next cycle
      // limitation: a live generator level never yields to main without a latch reset
      // source selection
      cur = eff_prio(s_reg.lvl, s_reg);
      case (s_reg.mode)
         2'(vicd_pkg::MODE_MAN_ELEC): begin
            s_next.src = 3'(vicd_pkg::SRC_ELEC);
            s_next.lvl = 2'd0;
         end
         2'(vicd_pkg::MODE_MAN_OPT): begin
            s_next.src = 3'(vicd_pkg::SRC_OPT);
            s_next.lvl = 2'd0;
         end
         default: begin
            // latching: only leave a level when it is lost
            if (!src_ok(cur, s_reg)) begin
               // scan all levels for first live one, background search
               for (int i = 0; i < 3; i++) begin
                  if (!found && src_ok(eff_prio(2'(i), s_reg), s_reg)) begin
                     nl = 2'(i);
                     found = 1'b1;
                  end
               end
               if (found)
                  s_next.lvl = nl;
            end
            if (cmd_wr && wb_dat_i[`VICD_CMD_LATCH])
               s_next.lvl = 2'd0;
            s_next.src = eff_prio(s_next.lvl, s_reg);
         end
      endcase
      // time code delay notes
      // video part is frames times samples per frame plus phase
      // phase is taken unsigned here, as the delay line sees it
      // the relative part is sign extended before the sum
      // a sum below zero would need samples not yet received,
      // so it is clamped to zero
      // the top end is clamped to the delay line length
      // recomputed each cycle, so it tracks every delay change
      // time code delay follows video delay plus relative part
      vid_smp = {16'h0000, s_reg.phase} + 32'(s_reg.frames) * 32'(`VICD_FRAME_SMP);
      ltc_sum = vid_smp + {{16{s_reg.ltc_rel[15]}}, s_reg.ltc_rel};
      if (ltc_sum[31])
         s_next.ltc_dly = 16'h0000;
      else if (ltc_sum > `VICD_LTC_MAX)
         s_next.ltc_dly = 16'(`VICD_LTC_MAX);
      else
         s_next.ltc_dly = ltc_sum[15:0];
      // channel pairing notes
      // default keeps the channels apart, left and right
      // the duplicated setting copies channel one to both sides
      // both words are registered on the same edge
      // group one channels to outputs
      s_next.ltc_l = ltc_ch1_i;
      s_next.ltc_r = (s_reg.pair == 1'b0) ? ltc_ch2_i : ltc_ch1_i;
      // bus notes
      // a request is taken when cyc and stb are up and ack is low
      // the write lands on that edge, ack follows for one cycle
      // sixteen-bit fields need both of their byte lanes selected;
      // a partial select leaves them untouched
      // unmapped writes are acked and dropped
      // a negative phase without a frame of delay is refused,
      // while the frame field of the same write still lands
      // wishbone slave, one wait then ack
      s_next.ack = req;
      if (req && wb_we_i) begin
         case (wb_adr_i)
            `VICD_OFS_CTRL: if (wb_sel_i[0]) begin
               s_next.mode = wb_dat_i[1:0];
               s_next.pair = wb_dat_i[4];
            end
            `VICD_OFS_PRIO: if (wb_sel_i[1:0] == 2'b11) begin
               s_next.prio0 = wb_dat_i[2:0];
               s_next.prio1 = wb_dat_i[6:4];
               s_next.prio2 = wb_dat_i[10:8];
            end
            `VICD_OFS_DELAY: begin
               // a negative phase is refused without a frame of delay
               if (wb_sel_i[1:0] == 2'b11 && (!wb_dat_i[15] || wb_dat_i[18:16] != 3'd0))
                  s_next.phase = wb_dat_i[15:0];
               if (wb_sel_i[2])
                  s_next.frames = wb_dat_i[18:16];
            end
            `VICD_OFS_LTC: if (wb_sel_i[1:0] == 2'b11) s_next.ltc_rel = wb_dat_i[15:0];
            `VICD_OFS_TIMES: begin
               if (wb_sel_i[1:0] == 2'b11) s_next.hold_t = wb_dat_i[15:0];
               if (wb_sel_i[3:2] == 2'b11) s_next.lock_t = wb_dat_i[31:16];
            end
            `VICD_OFS_ERRMASK: if (wb_sel_i[1:0] == 2'b11) s_next.mask = wb_dat_i[15:0];
            default: ;
         endcase
      end
      // read notes
      // the read word is latched each cycle from the address
      // it is valid when ack stands, as the request is held
      // priority reads blank rows that cannot be reached
      // status packs qualified presence, level and source
      // read mux, unmapped reads zero
      case (wb_adr_i)
         `VICD_OFS_CTRL:    s_next.rdat = {27'h0, s_reg.pair, 2'h0, s_reg.mode};
         `VICD_OFS_PRIO:    s_next.rdat = {17'h0, eff_prio(2'd2, s_reg), 1'b0,
                                           eff_prio(2'd1, s_reg), 1'b0, s_reg.prio0};
         `VICD_OFS_DELAY:   s_next.rdat = {13'h0, s_reg.frames, s_reg.phase};
         `VICD_OFS_LTC:     s_next.rdat = {16'h0, s_reg.ltc_rel};
         `VICD_OFS_TIMES:   s_next.rdat = {s_reg.lock_t, s_reg.hold_t};
         `VICD_OFS_ERRMASK: s_next.rdat = {16'h0, s_reg.mask};
         `VICD_OFS_STATUS:  s_next.rdat = {23'h0, s_reg.src, s_reg.lvl, 1'b0,
                             s_reg.qe.valid, s_reg.qo.valid, s_reg.sync_b[0]};
         `VICD_OFS_ERRCNT:  s_next.rdat = 32'(s_reg.errcnt);
         `VICD_OFS_PHASE:   s_next.rdat = {16'h0, phase_meas_i};
         default:           s_next.rdat = 32'h0000_0000;
      endcase
      // reset notes
      // applied last so it overrides every assignment above
      // default chain: electrical first, generator behind it
      // default hold and lock times and an open error mask
      // pairing starts as separate left and right
      // synchronous reset to defined values
      if (!rst_n_i) begin
         s_next = '0;
         s_next.prio0  = 3'(vicd_pkg::SRC_ELEC);
         s_next.prio1  = 3'(vicd_pkg::SRC_GEN);
         s_next.pair   = 1'(vicd_pkg::left_right_channel_pairing);
         s_next.hold_t = `VICD_RST_HOLD;
         s_next.lock_t = `VICD_RST_LOCK;
         s_next.mask   = `VICD_RST_MASK;
      end
   end

   // one register for the whole struct
   // no enable: every flop updates on every edge
   // reset is folded into the next value above
   // state register
   always_ff @(posedge mclk_i) begin
      s_reg <= s_next;
   end

   // output notes
   // all outputs are flops or plain decodes of flops
   // no input reaches an output through logic alone
   // fallback flags decode the registered source
   // freeze covers none and a selected input that is gone
   // frame and phase delays pass straight from the stored settings
   // outputs
   assign wb_ack_o      = s_reg.ack;
   assign wb_dat_o      = s_reg.rdat;
   assign sel_src_o     = s_reg.src;
   assign gen_black_o   = (s_reg.src == 3'(vicd_pkg::SRC_GEN));
   assign drv_off_o     = (s_reg.src == 3'(vicd_pkg::SRC_MUTE));
   // freeze when the selected real input is gone or nothing is selected
   assign freeze_o      = (s_reg.src == 3'(vicd_pkg::SRC_NONE)) |
                          (s_reg.src == 3'(vicd_pkg::SRC_ELEC) & ~s_reg.qe.valid) |
                          (s_reg.src == 3'(vicd_pkg::SRC_OPT) & ~s_reg.qo.valid);
   assign frame_delay_o = s_reg.frames;
   assign phase_delay_o = s_reg.phase;
   assign sc_phase_o    = s_reg.scph;
   assign ltc_delay_o   = s_reg.ltc_dly;
   assign ltc_left_o    = s_reg.ltc_l;
   assign ltc_right_o   = s_reg.ltc_r;
endmodule : vicd_top

//--- testbench/vicd_chk.sv
module vicd_chk (
   input wire logic        mclk_i,
   input wire logic        rst_n_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_ack_o,
   input wire logic        frame_tick_i,
   input wire logic [2:0]  sel_src_o,
   input wire logic        gen_black_o,
   input wire logic        drv_off_o,
   input wire logic [2:0]  sc_phase_o,
   input wire logic [15:0] ltc_delay_o
);
   // one domain, so clock and reset are given once
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);
   // bus answers one cycle after the take, for one cycle only
   ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
   ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("no ack");
   // subcarrier phase steps once per frame, wraps after eight
   sc_step_a: assert property (frame_tick_i |=> sc_phase_o == $past(sc_phase_o) + 3'h1)
      else $error("phase step");
   sc_hold_a: assert property (!frame_tick_i |=> $stable(sc_phase_o))
      else $error("phase moved");
   // fallback outputs tied to the chosen source
   gen_black_a: assert property (gen_black_o |-> sel_src_o == 3'h3)
      else $error("black off gen");
   mute_drv_a: assert property (drv_off_o |-> sel_src_o == 3'h4)
      else $error("mute off mute");
   ltc_cap_a: assert property (ltc_delay_o <= 16'h7D00)
      else $error("ltc over cap");
   src_range_a: assert property (sel_src_o <= 3'h4)
      else $error("bad source");
   cover property (gen_black_o);
   cover property (drv_off_o);
   cover property (frame_tick_i && sc_phase_o == 3'h7);
endmodule : vicd_chk

//--- testbench/vicd_src_model.sv
module vicd_src_model (
   input  wire logic        mclk_i,
   input  wire logic        elec_on_i,
   input  wire logic        opt_on_i,
   input  wire logic        err_on_i,
   output logic             elec_o,
   output logic             opt_o,
   output logic             lock_o,
   output logic             tick_o,
   output logic [15:0]      err_o,
   output logic [15:0]      ch1_o,
   output logic [15:0]      ch2_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [4:0] fcnt_reg;    // short frame of 32 cycles keeps runs brief
   initial begin
      {fcnt_reg, elec_o, opt_o, lock_o, tick_o} = '0;
      {err_o, ch1_o, ch2_o} = '0;
   end
   // source follows the bench's on/off wishes; audio words change every cycle
   always @(posedge mclk_i) begin
      fcnt_reg <= fcnt_reg + 5'h01;
      tick_o   <= (fcnt_reg == 5'h1F);
      elec_o   <= elec_on_i;
      opt_o    <= opt_on_i;
      lock_o   <= elec_on_i | opt_on_i; // reclocker locks to any live input
      err_o    <= err_on_i ? 16'h0001 : 16'h0000;
      ch1_o    <= ch1_o + 16'h0001;
      ch2_o    <= ~ch1_o;
   end
endmodule : vicd_src_model

//--- testbench/testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {logic [7:0] a; logic [31:0] e;} vicd_row_type;
   logic mclk_i = 1'b0, rst_n_i = 1'b0, wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
   logic [3:0] wb_sel_i = 4'h0;
   logic wb_ack_o, elec_sig_i, opt_sig_i, reclk_lock_i, frame_tick_i, freeze_o;
   logic gen_black_o, drv_off_o, elec_on = 1'b0, opt_on = 1'b0, err_on = 1'b0;
   logic [15:0] phase_meas_i = 16'h0123, err_flags_i, ltc_ch1_i, ltc_ch2_i;
   logic [15:0] phase_delay_o, ltc_delay_o, ltc_left_o, ltc_right_o;
   logic [2:0] sel_src_o, frame_delay_o, sc_phase_o;
   int bad_count = 0, total_checks = 0;
   vicd_row_type rows [6] = '{'{8'h00, 32'h0}, '{8'h10, 32'h00100010},
      '{8'h14, 32'h0000FFFF}, '{8'h08, 32'h0}, '{8'h0C, 32'h0}, '{8'h30, 32'h0}};
   always #25 mclk_i = ~mclk_i;
   vicd_top uut (.mclk_i, .rst_n_i, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_sel_i, .wb_we_i,
      .wb_cyc_i, .wb_stb_i, .wb_ack_o, .elec_sig_i, .opt_sig_i, .opt_fitted_i(1'b1),
      .reclk_lock_i, .frame_tick_i, .phase_meas_i, .err_flags_i, .ltc_ch1_i, .ltc_ch2_i,
      .sel_src_o, .freeze_o, .gen_black_o, .drv_off_o, .frame_delay_o, .phase_delay_o,
      .sc_phase_o, .ltc_delay_o, .ltc_left_o, .ltc_right_o);
   vicd_src_model src (.mclk_i, .elec_on_i(elec_on), .opt_on_i(opt_on), .err_on_i(err_on),
      .elec_o(elec_sig_i), .opt_o(opt_sig_i), .lock_o(reclk_lock_i), .tick_o(frame_tick_i),
      .err_o(err_flags_i), .ch1_o(ltc_ch1_i), .ch2_o(ltc_ch2_i));
   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : final_report
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH %0t seen %h want %h", $time, seen, exp);
      end
   endtask : chk
   // classic single cycle; request held until ack is sampled high
   task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk_i);
      {wb_adr_i, wb_we_i, wb_dat_i, wb_sel_i} <= {a, w, d, 4'hF};
      {wb_cyc_i, wb_stb_i} <= 2'b11;
      do begin @(posedge mclk_i); n++; end while (wb_ack_o !== 1'b1 && n < 50);
      if (n >= 50) begin chk(0, 1); final_report(); end
      q = wb_dat_o;
      {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
   endtask : wb
   // bounded wait for the selector to settle on a source
   task automatic wait_src(input logic [2:0] s);
      int n;
      n = 0;
      while (sel_src_o !== s && n < 300) begin @(posedge mclk_i); n++; end
      chk(sel_src_o, s);
      if (n >= 300) final_report();
   endtask : wait_src
   initial begin
      repeat (16) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      foreach (rows[i]) begin wb(rows[i].a, 0, 0); chk(q, rows[i].e); end
      $display("test reset values done");
      wb(8'h10, 1, 32'h00020002);
      wb(8'h04, 1, 32'h031);
      elec_on <= 1'b1;
      repeat (10) @(posedge mclk_i);
      wb(8'h24, 1, 32'h2);
      wait_src(3'h1);
      wb(8'h18, 0, 0); chk(q[2:0], 3'b101);
      elec_on <= 1'b0;
      wait_src(3'h3); chk(gen_black_o, 1);
      elec_on <= 1'b1;
      repeat (30) @(posedge mclk_i); chk(sel_src_o, 3'h3);
      wb(8'h24, 1, 32'h2); wait_src(3'h1);
      wb(8'h04, 1, 32'h041); elec_on <= 1'b0;
      wait_src(3'h4); chk(drv_off_o, 1);
      wb(8'h04, 1, 32'h213); wb(8'h04, 0, 0); chk(q, 32'h003);
      wb(8'h04, 1, 32'h021);
      repeat (30) @(posedge mclk_i); chk(freeze_o, 1);
      opt_on <= 1'b1; wait_src(3'h2);
      $display("test fallback done");
      opt_on <= 1'b0; elec_on <= 1'b1; wb(8'h00, 1, 32'h1); wait_src(3'h1);
      elec_on <= 1'b0; repeat (30) @(posedge mclk_i);
      chk(sel_src_o, 3'h1); chk(freeze_o, 1);
      chk(ltc_right_o, {16'h0, ~(ltc_left_o - 16'h0001)});
      wb(8'h00, 1, 32'h11); repeat (2) @(posedge mclk_i);
      chk(ltc_right_o, ltc_left_o);
      wb(8'h08, 1, 32'h00008000); chk({frame_delay_o, phase_delay_o}, 0);
      wb(8'h08, 1, 32'h00058000); chk({frame_delay_o, phase_delay_o}, 19'h58000);
      wb(8'h08, 1, 32'h00050000); repeat (4) @(posedge mclk_i);
      chk(ltc_delay_o, 16'h2580);
      wb(8'h0C, 1, 32'h61A8); repeat (4) @(posedge mclk_i); chk(ltc_delay_o, 16'h7D00);
      wb(8'h0C, 1, 32'hDA7F); repeat (4) @(posedge mclk_i); chk(ltc_delay_o, 16'h0);
      $display("test delay done");
      err_on <= 1'b1; repeat (10) @(posedge mclk_i); err_on <= 1'b0;
      wb(8'h1C, 0, 0); chk(q == 0, 0);
      wb(8'h24, 1, 32'h1); wb(8'h1C, 0, 0); chk(q, 0);
      wb(8'h14, 1, 32'h0); err_on <= 1'b1; repeat (10) @(posedge mclk_i);
      wb(8'h1C, 0, 0); chk(q, 0);
      wb(8'h20, 0, 0); chk(q, 32'h0123);
      $display("test status done");
      final_report();
   end
endmodule : testbench
bind vicd_top vicd_chk chk_i (.mclk_i, .rst_n_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
   .frame_tick_i, .sel_src_o, .gen_black_o, .drv_off_o, .sc_phase_o, .ltc_delay_o);
